// *** rtl/uabd_pkg.sv ***
// Shared constants for the autobaud detector and the remote sync sender.
// Assumes a single 200 MHz system clock on both ends.
package uabd_pkg;

  // ----------------------------------------------------------------
  // Register map (APB, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIVISOR = 8'h04;
  localparam logic [7:0] OFF_RXDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // CTRL fields
  localparam int CTRL_ARM = 0;
  localparam int CTRL_BRK = 1;
  localparam int CTRL_ASYNC = 2;
  localparam int CTRL_WIDE = 3;
  localparam int CTRL_HS = 4;
  localparam int CTRL_RXFLAG = 8;
  localparam int CTRL_HOLD = 9;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // STATUS / MASK fields
  localparam int ST_DONE = 0;
  localparam int ST_CARRY = 1;
  localparam int ST_WIDTH = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [12:0] CLK_DIV_SLOW = 13'h0200;
  localparam logic [12:0] CLK_DIV_MID = 13'h0080;
  localparam logic [12:0] CLK_DIV_FAST = 13'h0020;
  localparam int CAL_SCALE_SHIFT = 3;
  localparam logic [2:0] EDGE_LAST = 3'h5;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam int FRAME_BITS = 10;

endpackage

// *** rtl/uabd_link_if.sv ***
// Serial line between remote sender and autobaud detector.
// Assumes both ends share sys_clk; the line itself is asynchronous.
`timescale 1ns/1ps
interface uabd_link_if;
  logic serial_line;
  modport dev (input serial_line);
  modport rem (output serial_line);
endinterface

// *** rtl/uabd_sync_sender.sv ***
// Remote transmitter: sends one frame of the sync character.
// Assumes the caller holds bit_period stable while busy.
`timescale 1ns/1ps
module uabd_sync_sender (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic send,
  input wire logic [15:0] bit_period,
  output logic busy,
  uabd_link_if.rem link
);

  logic [9:0] frame;
  logic [3:0] bit_left;
  logic [15:0] tick_cnt;

  // ----------------------------------------------------------------
  // Frame shifter: start, 8 data LSB first, stop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame <= 10'h3ff;
      bit_left <= 4'h0;
      tick_cnt <= 16'h0000;
    end else if (bit_left == 4'h0) begin
      if (send) begin
        frame <= {1'b1, uabd_pkg::SYNC_CHAR, 1'b0};
        bit_left <= 4'(uabd_pkg::FRAME_BITS);
        tick_cnt <= 16'h0000;
      end
    end else if (tick_cnt + 16'h0001 >= bit_period) begin
      tick_cnt <= 16'h0000;
      frame <= {1'b1, frame[9:1]};
      bit_left <= bit_left - 4'h1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  assign busy = (bit_left != 4'h0);
  // Idle line is high; only bit 0 of the shifter is on the wire
  assign link.serial_line = (bit_left == 4'h0) ? 1'b1 : frame[0];

endmodule

// *** rtl/uabd_detector.sv ***
// Autobaud detector: measures the bit period of an incoming sync char.
// Assumes an APB master on sys_clk and an asynchronous serial line.
//
// How it works
// - Measure only in async mode, wake-on-break included
// - Arming clears counter, then awaits start bit
// - Start bit while armed begins the measurement
// - Line edges time the counter, not sampling
// - Remote sends 55h as the sync character
// - Span covers low and high bit times
// - Counting starts at first rising line edge
// - Fifth rising edge leaves period in divisor
// - Fifth rising edge clears autobaud_enable
// - Counter runs at one eighth configured rate
// - Selects pick osc/512, osc/128 or osc/32
// - Divisor pair always forms 16-bit counter
// - Software checks high byte zero in 8-bit modes
// - Receiver held idle throughout measurement
// - Fifth rising edge sets receive_int_flag
// - Reading receive_data_reg clears receive_int_flag
// - With wake-on-break, measure character after break
// - Software keeps baud within measurable range
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module uabd_detector (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic receive_int_flag,
  output logic receiver_hold,
  uabd_link_if.dev link
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_BRK_LOW = 5'b00010,
    ST_ARMED = 5'b00100,
    ST_START = 5'b01000,
    ST_COUNT = 5'b10000
  } uabd_state_t;

  uabd_state_t state;
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic rise;
  logic fall;
  logic autobaud_enable;
  logic wake_on_break_enable;
  logic async_mode;
  logic wide_divisor_select;
  logic high_speed_select;
  logic [15:0] baud_divisor;
  logic [12:0] pre_cnt;
  logic [12:0] pre_period;
  logic pre_tick;
  logic [2:0] edge_cnt;
  logic done;
  logic carry;
  logic [uabd_pkg::ST_WIDTH-1:0] status;
  logic [uabd_pkg::ST_WIDTH-1:0] mask;
  logic [uabd_pkg::ST_WIDTH-1:0] status_set;
  logic wr_en;
  logic rd_en;

  // Counter clock period in sys_clk cycles, already slowed by eight
  function automatic logic [12:0] counter_period(input logic wide,
                                                 input logic hs);
    logic [12:0] base;
    base = uabd_pkg::CLK_DIV_MID;
    if (!wide && !hs) begin
      base = uabd_pkg::CLK_DIV_SLOW;
    end else if (wide && hs) begin
      base = uabd_pkg::CLK_DIV_FAST;
    end
    return 13'(base << uabd_pkg::CAL_SCALE_SHIFT);
  endfunction

  // ----------------------------------------------------------------
  // Line synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= link.serial_line;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign rise = rx_sync && !rx_prev;
  assign fall = !rx_sync && rx_prev;

  // ----------------------------------------------------------------
  // Counter clock prescaler
  // ----------------------------------------------------------------
  assign pre_period = counter_period(wide_divisor_select,
                                     high_speed_select);
  assign pre_tick = (state == ST_COUNT) && (pre_cnt == pre_period - 13'h1);

  // Restarted at the first rising edge so each run sees full periods
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt <= 13'h0000;
    end else if (state != ST_COUNT || pre_tick) begin
      pre_cnt <= 13'h0000;
    end else begin
      pre_cnt <= pre_cnt + 13'h1;
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  assign done = (state == ST_COUNT) && rise &&
                (edge_cnt == uabd_pkg::EDGE_LAST - 3'h1);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      edge_cnt <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (autobaud_enable && async_mode) begin
            state <= wake_on_break_enable ? ST_BRK_LOW : ST_ARMED;
          end
        end
        ST_BRK_LOW: begin
          // Break ends on its rising edge; next character is measured
          if (rise) begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (fall) begin
            state <= ST_START;
          end
        end
        ST_START: begin
          if (rise) begin
            state <= ST_COUNT;
            edge_cnt <= 3'h1;
          end
        end
        ST_COUNT: begin
          if (done) begin
            state <= ST_IDLE;
            edge_cnt <= 3'h0;
          end else if (rise) begin
            edge_cnt <= edge_cnt + 3'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          edge_cnt <= 3'h0;
        end
      endcase
      // Software may withdraw the arm bit at any time
      if (!autobaud_enable || !async_mode) begin
        state <= ST_IDLE;
        edge_cnt <= 3'h0;
      end
    end
  end

  assign receiver_hold = (state != ST_IDLE);

  // ----------------------------------------------------------------
  // Divisor pair as 16-bit counter
  // ----------------------------------------------------------------
  assign carry = pre_tick && (baud_divisor == 16'hffff);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_divisor <= 16'h0000;
    end else if (state == ST_IDLE && autobaud_enable && async_mode) begin
      baud_divisor <= 16'h0000;
    end else if (pre_tick && !done) begin
      baud_divisor <= baud_divisor + 16'h0001;
    end else if (state == ST_IDLE && wr_en &&
                 paddr == uabd_pkg::OFF_DIVISOR) begin
      baud_divisor <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // APB slave and control bits
  // ----------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   !(paddr == uabd_pkg::OFF_CTRL ||
                     paddr == uabd_pkg::OFF_DIVISOR ||
                     paddr == uabd_pkg::OFF_RXDATA ||
                     paddr == uabd_pkg::OFF_STATUS ||
                     paddr == uabd_pkg::OFF_MASK);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {high_speed_select, wide_divisor_select, async_mode,
       wake_on_break_enable, autobaud_enable} <= uabd_pkg::CTRL_RESET;
    end else begin
      if (wr_en && paddr == uabd_pkg::OFF_CTRL) begin
        autobaud_enable <= pwdata[uabd_pkg::CTRL_ARM];
        wake_on_break_enable <= pwdata[uabd_pkg::CTRL_BRK];
        async_mode <= pwdata[uabd_pkg::CTRL_ASYNC];
        wide_divisor_select <= pwdata[uabd_pkg::CTRL_WIDE];
        high_speed_select <= pwdata[uabd_pkg::CTRL_HS];
      end
      // Hardware completion overrides a same-cycle rewrite of the arm bit
      if (done) begin
        autobaud_enable <= 1'b0;
      end
    end
  end

  // Read of receive data register clears flag; new set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      receive_int_flag <= 1'b0;
    end else if (done) begin
      receive_int_flag <= 1'b1;
    end else if (rd_en && paddr == uabd_pkg::OFF_RXDATA) begin
      receive_int_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign status_set = {carry, done};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
    end else if (rd_en && paddr == uabd_pkg::OFF_STATUS) begin
      status <= status_set;
    end else begin
      status <= status | status_set;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask <= '0;
    end else if (wr_en && paddr == uabd_pkg::OFF_MASK) begin
      mask <= pwdata[uabd_pkg::ST_WIDTH-1:0];
    end
  end

  assign irq = |(status & mask);

  // ----------------------------------------------------------------
  // Read data, registered in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        uabd_pkg::OFF_CTRL: begin
          prdata[uabd_pkg::CTRL_ARM] <= autobaud_enable;
          prdata[uabd_pkg::CTRL_BRK] <= wake_on_break_enable;
          prdata[uabd_pkg::CTRL_ASYNC] <= async_mode;
          prdata[uabd_pkg::CTRL_WIDE] <= wide_divisor_select;
          prdata[uabd_pkg::CTRL_HS] <= high_speed_select;
          prdata[uabd_pkg::CTRL_RXFLAG] <= receive_int_flag;
          prdata[uabd_pkg::CTRL_HOLD] <= receiver_hold;
        end
        // High half zero after an 8-bit mode run means no carry
        uabd_pkg::OFF_DIVISOR: prdata[15:0] <= baud_divisor;
        uabd_pkg::OFF_STATUS: begin
          prdata[uabd_pkg::ST_WIDTH-1:0] <= status;
        end
        uabd_pkg::OFF_MASK: prdata[uabd_pkg::ST_WIDTH-1:0] <= mask;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// *** testbench/uabd_assertions.sv ***
// Concurrent checks on the serial link and the detector outputs.
// Instantiated beside the link interface in the bench top.
`timescale 1ns/1ps
module uabd_assertions (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic serial_line,
  input wire logic busy,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic receive_int_flag,
  input wire logic receiver_hold
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic rx_rd;
  logic arm_wr;
  assign rx_rd = psel && penable && !pwrite &&
                 paddr == uabd_pkg::OFF_RXDATA;
  assign arm_wr = psel && penable && pwrite &&
                  paddr == uabd_pkg::OFF_CTRL &&
                  pwdata[uabd_pkg::CTRL_ARM] &&
                  pwdata[uabd_pkg::CTRL_ASYNC];

  // Control lands at the access edge, the state one edge later
  arm_by_write_a: assert property ($rose(receiver_hold) |->
    $past(arm_wr, 2))
    else $error("hold rose without an arming write");
  flag_at_end_a: assert property ($rose(receive_int_flag) |->
    $past(receiver_hold) && !receiver_hold)
    else $error("flag rose outside the end of measurement");
  flag_on_stop_a: assert property ($rose(receive_int_flag) |->
    serial_line)
    else $error("flag rose while line low");
  flag_sticky_a: assert property (receive_int_flag && !rx_rd |=>
    receive_int_flag)
    else $error("flag dropped without data read");
  flag_clear_a: assert property (rx_rd && !receiver_hold |=>
    !receive_int_flag)
    else $error("flag survived data read");
  rx_data_zero_a: assert property (rx_rd |-> prdata == 32'h0)
    else $error("receive data not zero");
  line_idle_a: assert property (!busy |-> serial_line)
    else $error("line low while sender idle");
  start_bit_a: assert property ($rose(busy) |-> !serial_line)
    else $error("frame did not open with start bit");
  unmapped_err_a: assert property (psel && penable &&
    paddr > uabd_pkg::OFF_MASK |-> pslverr)
    else $error("unmapped access without error");

  measure_done_c: cover property ($rose(receive_int_flag));
  abort_c: cover property ($fell(receiver_hold) && !receive_int_flag);
  unmapped_c: cover property (psel && penable && pslverr);
endmodule

// *** testbench/uart_autobaud_detect_test.sv ***
// Bench top: sender and detector joined by the link, APB driven here.
// Assumes a zero-wait APB slave and a 55h frame from the sender.
`timescale 1ns/1ps
module uart_autobaud_detect_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic send = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] bit_period = 16'h044c;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq, receive_int_flag, receiver_hold, busy;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int num_checks = 0;

  uabd_link_if i_uabd_link_if ();
  uabd_sync_sender i_uabd_sync_sender (.sys_clk(sys_clk),
    .reset_n(reset_n), .send(send), .bit_period(bit_period),
    .busy(busy), .link(i_uabd_link_if.rem));
  uabd_detector i_uabd_detector (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .receive_int_flag(receive_int_flag),
    .receiver_hold(receiver_hold), .link(i_uabd_link_if.dev));
  uabd_assertions i_uabd_assertions (.sys_clk(sys_clk),
    .reset_n(reset_n), .serial_line(i_uabd_link_if.serial_line),
    .busy(busy), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .receive_int_flag(receive_int_flag),
    .receiver_hold(receiver_hold));

  initial forever #2.5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Leading edge keeps one idle cycle, so no signal is set twice at once
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      failures++;
      end_of_test();
    end
  endtask

  // Waits out a frame in flight; the sender ignores send while busy
  task automatic fire();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      end_of_test();
    end
    @(posedge sys_clk);
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic reset_vals();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
  endtask

  // Arming without async mode must not measure; clearing the arm bit aborts
  task automatic no_async();
    apb(1'b1, uabd_pkg::OFF_CTRL, 32'h1);
    fire();
    repeat (11200) @(posedge sys_clk);
    chk({30'h0, receiver_hold, receive_int_flag}, 32'h0);
    apb(1'b1, uabd_pkg::OFF_CTRL, 32'h5);
    apb(1'b0, uabd_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h205);
    apb(1'b1, uabd_pkg::OFF_CTRL, 32'h4);
    // Abort reaches the state one edge after the control write
    @(posedge sys_clk);
    #1;
    chk({30'h0, receiver_hold, receive_int_flag}, 32'h0);
  endtask

  // With wake-on-break the start-bit rise ends the break; the rest of that character cannot finish a run
  task automatic brk_wait();
    int n;
    n = 0;
    apb(1'b1, uabd_pkg::OFF_CTRL, 32'h1f);
    fire();
    @(posedge sys_clk);
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      end_of_test();
    end
    repeat (8) @(posedge sys_clk);
    chk({31'h0, receive_int_flag}, 32'h0);
    apb(1'b0, uabd_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h21f);
    apb(1'b1, uabd_pkg::OFF_CTRL, 32'h4);
  endtask

  task automatic measure(input logic [1:0] sel, input logic [15:0] exp,
                         input logic msk);
    logic [31:0] c;
    int n;
    c = {27'h0, sel, 3'h0};
    n = 0;
    apb(1'b1, uabd_pkg::OFF_MASK, {31'h0, msk});
    apb(1'b1, uabd_pkg::OFF_DIVISOR, 32'h1234);
    apb(1'b0, uabd_pkg::OFF_DIVISOR, 32'h0);
    chk(rd, 32'h1234);
    apb(1'b1, uabd_pkg::OFF_CTRL, c | 32'h5);
    apb(1'b0, uabd_pkg::OFF_DIVISOR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, uabd_pkg::OFF_CTRL, 32'h0);
    chk(rd, c | 32'h205);
    fire();
    while (receive_int_flag !== 1'b1 && n < 30000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 30000) begin
      failures++;
      end_of_test();
    end
    chk({31'h0, receive_int_flag}, 32'h1);
    chk({31'h0, irq}, {31'h0, msk});
    apb(1'b0, uabd_pkg::OFF_CTRL, 32'h0);
    chk(rd, c | 32'h104);
    apb(1'b0, uabd_pkg::OFF_DIVISOR, 32'h0);
    chk(rd, {16'h0, exp});
    apb(1'b0, uabd_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, uabd_pkg::OFF_RXDATA, 32'h0);
    chk(rd, 32'h0);
    #1;
    chk({30'h0, irq, receive_int_flag}, 32'h0);
  endtask

  initial begin
    int p;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    reset_vals();
    no_async();
    // Span of eight bits over eight counter-clock prescale periods
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 512 : (i == 3) ? 32 : 128;
      measure(i[1:0], 16'((8 * 1100) / (8 * p)), i != 0);
    end
    brk_wait();
    end_of_test();
  end
endmodule
